// ==== logic/intp_pkg.sv ====
// constants for the interrupt prioritizer and vector unit
// assumes a single core clock; all users reference names as intp_pkg::name
package intp_pkg;
	// register byte offsets on the control bus
	localparam logic [7:0] OFS_MASK = 8'h00;
	localparam logic [7:0] OFS_PEND = 8'h04;
	localparam logic [7:0] OFS_PTS_SEL = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0c;
	localparam logic [7:0] OFS_CAPTURE = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	// reset values
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam logic [15:0] PTS_SEL_RST = 16'h0000;
	localparam logic [3:0] CTRL_RST = 4'h0;
	// control field positions
	localparam int CTRL_PIN_SEL = 0;
	localparam int CTRL_EXT_HSI0 = 1;
	localparam int CTRL_EXT_EXT1 = 2;
	localparam int CTRL_EXT_NMI = 3;
	// vector locations
	localparam logic [15:0] VEC_UNIMPL = 16'h2012;
	localparam logic [15:0] VEC_SWTRAP = 16'h2010;
	localparam logic [15:0] VEC_NMI = 16'h203e;
	localparam logic [15:0] VEC_LO_BASE = 16'h2000;
	localparam logic [15:0] VEC_HI_BASE = 16'h2030;
	localparam logic [15:0] PTS_BASE = 16'h2040;
	// source numbers and bit masks
	localparam int SRC_HSI0 = 4;
	localparam int SRC_FAST_OUT = 3;
	localparam int SRC_SERIAL = 6;
	localparam int SRC_EXT = 7;
	localparam int SRC_TX = 8;
	localparam int SRC_RX = 9;
	localparam int SRC_T2CAP = 11;
	localparam int SRC_EXT1 = 13;
	localparam int SRC_NMI = 15;
	localparam logic [15:0] NMI_BIT = 16'h8000;
	// offered source codes above the prioritized range
	localparam logic [4:0] CODE_UNIMPL = 5'h10;
	localparam logic [4:0] CODE_SWTRAP = 5'h11;
	// pin indices into the synchronised pin vector
	localparam int PIN_P2_2 = 0;
	localparam int PIN_P0_7 = 1;
	localparam int PIN_HSI0 = 2;
	localparam int PIN_T2CAP = 3;
	localparam int PIN_EXT1 = 4;
	localparam int PIN_NMI = 5;
	localparam int NPIN = 6;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_OFFER = 2'b10} intp_state_t;
endpackage

// ==== logic/intp_edge.sv ====
// two-flop synchroniser and rising-edge detector for asynchronous pins
// assumes pins are slow compared to clk; each rising edge yields one pulse
`timescale 1ns/100ps
module intp_edge #(
	parameter int W = 6
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// pins and edges
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] rise
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					s1_reg[i] <= 1'b0;
					s2_reg[i] <= 1'b0;
					s3_reg[i] <= 1'b0;
				end else if (ce) begin
					s1_reg[i] <= pin_in[i];
					s2_reg[i] <= s1_reg[i];
					s3_reg[i] <= s2_reg[i];
				end
			end
			// first stage is read only by the second
			assign rise[i] = s2_reg[i] & ~s3_reg[i];
		end
	endgenerate
endmodule

// ==== logic/intp_core.sv ====
// interrupt prioritizer and vector unit with axi4-lite control registers
// assumes peripheral events and trap pulses are one-cycle pulses on clk
//
// Notes on behaviour
// - the two traps skip arbitration, go out first and vector to 2012h and 2010h, never via server.
// - source 15 beats every prioritized request and vectors to 203eh, never via server.
// - a pending request routed to the transaction server wins over every ordinary request.
// - ordinary requests are ranked by number, 0 lowest and 14 highest.
// - sources 4, 7, 11, 13 and 15 can each be fed from their own external pin.
// - with the combined serial source masked, receive and transmit flags raise sources 9 and 8.
// - with the combined serial source enabled, either flag raises source 6 at vector 200ch.
// - source 7 comes from one of two pins and vectors to 200eh, server vector 204eh.
// - any of the six fast-output events raises source 3, vector 2006h, server vector 2046h.
// - the pin select bit at 1 takes source 7 from port-0 bit 7, at 0 from port-2 bit 2.
// - a rising capture-pin edge latches the timer-2 count and raises source 11.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
module intp_core (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// axi4-lite slave
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// on-chip event sources
	input wire logic [15:0] periph_evt,
	input wire logic [5:0] fast_output_unit_evt,
	input wire logic receive_done_flag,
	input wire logic transmit_done_flag,
	input wire logic unimpl_opcode_trap,
	input wire logic software_trap,
	input wire logic [15:0] timer2_count,
	// external pins
	input wire logic port2_bit2_pin,
	input wire logic port0_bit7_pin,
	input wire logic fast_input_unit_pin0,
	input wire logic timer2_capture_input,
	input wire logic external_interrupt1_pin,
	input wire logic nmi_pin,
	// cpu vector handshake
	output logic int_req,
	output logic [15:0] int_vector,
	output logic [4:0] int_src,
	output logic int_transaction_server,
	input wire logic int_ack
);
	logic [15:0] mask_reg, pend_reg, pend_next, pts_sel_reg, capture_reg;
	logic [3:0] ctrl_reg;
	logic unimpl_reg, swtrap_reg, aw_held_reg, w_held_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	intp_pkg::intp_state_t state_reg;
	logic [intp_pkg::NPIN-1:0] pin_rise;

	function automatic logic [3:0] hi_idx(input logic [15:0] v);
		hi_idx = 4'h0;
		for (int k = 0; k < 16; k++) begin
			if (v[k]) begin
				hi_idx = k[3:0];
			end
		end
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	intp_edge #(.W(intp_pkg::NPIN)) u_edge (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.pin_in({nmi_pin, external_interrupt1_pin, timer2_capture_input,
			fast_input_unit_pin0, port0_bit7_pin, port2_bit2_pin}),
		.rise(pin_rise)
	);

	////////////////////////////////////////////////////////////////////////////////
	// event routing into pending bits
	wire ser_comb = mask_reg[intp_pkg::SRC_SERIAL];
	wire ext7_edge = ctrl_reg[intp_pkg::CTRL_PIN_SEL] ? pin_rise[intp_pkg::PIN_P0_7]
		: pin_rise[intp_pkg::PIN_P2_2];
	wire cap_edge = pin_rise[intp_pkg::PIN_T2CAP];
	logic [15:0] set_vec;
	always_comb begin
		set_vec = periph_evt;
		set_vec[intp_pkg::SRC_FAST_OUT] = periph_evt[3] | (|fast_output_unit_evt);
		set_vec[intp_pkg::SRC_SERIAL] = periph_evt[6]
			| (ser_comb & (receive_done_flag | transmit_done_flag));
		set_vec[intp_pkg::SRC_TX] = periph_evt[8] | (~ser_comb & transmit_done_flag);
		set_vec[intp_pkg::SRC_RX] = periph_evt[9] | (~ser_comb & receive_done_flag);
		set_vec[intp_pkg::SRC_EXT] = periph_evt[7] | ext7_edge;
		set_vec[intp_pkg::SRC_T2CAP] = periph_evt[11] | cap_edge;
		set_vec[intp_pkg::SRC_HSI0] = periph_evt[4]
			| (ctrl_reg[intp_pkg::CTRL_EXT_HSI0] & pin_rise[intp_pkg::PIN_HSI0]);
		set_vec[intp_pkg::SRC_EXT1] = periph_evt[13]
			| (ctrl_reg[intp_pkg::CTRL_EXT_EXT1] & pin_rise[intp_pkg::PIN_EXT1]);
		set_vec[intp_pkg::SRC_NMI] = periph_evt[15]
			| (ctrl_reg[intp_pkg::CTRL_EXT_NMI] & pin_rise[intp_pkg::PIN_NMI]);
	end

	////////////////////////////////////////////////////////////////////////////////
	// arbitration
	wire [15:0] act = pend_reg & (mask_reg | intp_pkg::NMI_BIT);
	wire [15:0] pts_act = act & pts_sel_reg & ~intp_pkg::NMI_BIT;
	wire [15:0] ord_act = act & ~pts_act;
	wire trap_any = unimpl_reg | swtrap_reg;
	wire nmi_win = ~trap_any & act[intp_pkg::SRC_NMI];
	wire pts_win = ~trap_any & ~nmi_win & (|pts_act);
	wire sel_valid = trap_any | (|act);
	wire [3:0] sel_num = pts_win ? hi_idx(pts_act) : hi_idx(ord_act);
	wire [4:0] sel_src = unimpl_reg ? intp_pkg::CODE_UNIMPL
		: swtrap_reg ? intp_pkg::CODE_SWTRAP : {1'b0, sel_num};
	wire [15:0] num_ofs = {12'h000, sel_num[2:0], 1'b0};
	wire [15:0] ord_vec = (sel_num[3] ? intp_pkg::VEC_HI_BASE : intp_pkg::VEC_LO_BASE) + num_ofs;
	wire [15:0] pts_vec = intp_pkg::PTS_BASE + {11'h000, sel_num, 1'b0};
	wire [15:0] sel_vec = unimpl_reg ? intp_pkg::VEC_UNIMPL
		: swtrap_reg ? intp_pkg::VEC_SWTRAP
		: nmi_win ? intp_pkg::VEC_NMI
		: pts_win ? pts_vec : ord_vec;

	////////////////////////////////////////////////////////////////////////////////
	// cpu handshake
	wire offering = state_reg == intp_pkg::ST_OFFER;
	wire ack_fire = ce & offering & int_ack;
	wire load = ce & (state_reg == intp_pkg::ST_IDLE) & sel_valid;
	assign int_req = offering;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= intp_pkg::ST_IDLE;
			int_vector <= 16'h0000;
			int_src <= 5'h00;
			int_transaction_server <= 1'b0;
		end else if (load) begin
			state_reg <= intp_pkg::ST_OFFER;
			int_vector <= sel_vec;
			int_src <= sel_src;
			int_transaction_server <= pts_win;
		end else if (ack_fire) begin
			state_reg <= intp_pkg::ST_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pending state; a new event wins over a clear in the same cycle
	wire wr_fire = ce & aw_held_reg & w_held_reg & ~s_bvalid;
	wire [15:0] ack_clr = (ack_fire & ~int_src[4]) ? (16'h0001 << int_src[3:0]) : 16'h0000;
	wire [15:0] w1c = (wr_fire & aw_addr_reg == intp_pkg::OFS_PEND)
		? merge16(16'h0000, w_data_reg, w_strb_reg) : 16'h0000;
	assign pend_next = (pend_reg & ~ack_clr & ~w1c) | set_vec;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pend_reg <= 16'h0000;
			unimpl_reg <= 1'b0;
			swtrap_reg <= 1'b0;
			capture_reg <= 16'h0000;
		end else if (ce) begin
			pend_reg <= pend_next;
			unimpl_reg <= unimpl_opcode_trap
				| (unimpl_reg & ~(ack_fire & int_src == intp_pkg::CODE_UNIMPL));
			swtrap_reg <= software_trap
				| (swtrap_reg & ~(ack_fire & int_src == intp_pkg::CODE_SWTRAP));
			if (cap_edge) begin
				capture_reg <= timer2_count;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave
	wire wr_known = aw_addr_reg == intp_pkg::OFS_MASK || aw_addr_reg == intp_pkg::OFS_PEND
		|| aw_addr_reg == intp_pkg::OFS_PTS_SEL || aw_addr_reg == intp_pkg::OFS_CTRL;
	wire [15:0] wr_merged_ctrl = merge16({12'h000, ctrl_reg}, w_data_reg, w_strb_reg);
	assign s_awready = ~aw_held_reg;
	assign s_wready = ~w_held_reg;
	assign s_arready = ~s_rvalid;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp <= intp_pkg::RESP_OKAY;
			mask_reg <= intp_pkg::MASK_RST;
			pts_sel_reg <= intp_pkg::PTS_SEL_RST;
			ctrl_reg <= intp_pkg::CTRL_RST;
		end else if (ce) begin
			if (s_awvalid & ~aw_held_reg) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_awaddr;
			end
			if (s_wvalid & ~w_held_reg) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_wdata;
				w_strb_reg <= s_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= wr_known ? intp_pkg::RESP_OKAY : intp_pkg::RESP_SLVERR;
				if (aw_addr_reg == intp_pkg::OFS_MASK) begin
					mask_reg <= merge16(mask_reg, w_data_reg, w_strb_reg);
				end
				if (aw_addr_reg == intp_pkg::OFS_PTS_SEL) begin
					pts_sel_reg <= merge16(pts_sel_reg, w_data_reg, w_strb_reg);
				end
				if (aw_addr_reg == intp_pkg::OFS_CTRL) begin
					ctrl_reg <= wr_merged_ctrl[3:0];
				end
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	wire [31:0] rd_mux = (s_araddr == intp_pkg::OFS_MASK) ? {16'h0000, mask_reg}
		: (s_araddr == intp_pkg::OFS_PEND) ? {16'h0000, pend_reg}
		: (s_araddr == intp_pkg::OFS_PTS_SEL) ? {16'h0000, pts_sel_reg}
		: (s_araddr == intp_pkg::OFS_CTRL) ? {28'h0000000, ctrl_reg}
		: (s_araddr == intp_pkg::OFS_CAPTURE) ? {16'h0000, capture_reg}
		: (s_araddr == intp_pkg::OFS_STATUS) ? {int_vector, 10'h000, int_req, int_src}
		: 32'h0000_0000;
	wire rd_known = s_araddr <= intp_pkg::OFS_STATUS && s_araddr[1:0] == 2'b00;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= intp_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_arvalid & ~s_rvalid) begin
				s_rvalid <= 1'b1;
				s_rdata <= rd_mux;
				s_rresp <= rd_known ? intp_pkg::RESP_OKAY : intp_pkg::RESP_SLVERR;
			end else if (s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_trap;
		load & unimpl_reg |=> int_req && int_vector == 16'h2012 && !int_transaction_server;
	endproperty
	a_trap: assert property (p_trap) else $error("unimplemented trap vector wrong");
	property p_swtrap;
		load & ~unimpl_reg & swtrap_reg |=> int_vector == 16'h2010 && int_src == 5'h11;
	endproperty
	a_swtrap: assert property (p_swtrap) else $error("software trap vector wrong");
	property p_nmi;
		load & ~trap_any & pend_reg[15] |=> int_vector == 16'h203e && !int_transaction_server;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi did not win");
	property p_pts;
		load & ~trap_any & ~pend_reg[15] & (|pts_act) |=> int_transaction_server
			&& int_vector == 16'h2040 + {10'h000, int_src, 1'b0};
	endproperty
	a_pts: assert property (p_pts) else $error("server request lost to ordinary");
	property p_order;
		int_req & ~int_transaction_server & ~int_src[4] & $rose(int_req)
			|-> ($past(ord_act) >> int_src[3:0]) == 16'h0001;
	endproperty
	a_order: assert property (p_order) else $error("not the highest ordinary source");
	property p_ext_nmi;
		ce & ctrl_reg[3] & pin_rise[5] |=> pend_reg[15];
	endproperty
	a_ext_nmi: assert property (p_ext_nmi) else $error("external nmi pin ignored");
	property p_split;
		ce & ~mask_reg[6] & receive_done_flag |=> pend_reg[9];
	endproperty
	a_split: assert property (p_split) else $error("receive flag not routed");
	property p_comb;
		ce & mask_reg[6] & transmit_done_flag & ~periph_evt[8] & ~pend_reg[8] |=> pend_reg[6]
			&& !pend_reg[8];
	endproperty
	a_comb: assert property (p_comb) else $error("transmit flag not combined");
	property p_ext7;
		int_req & int_src == 5'h07 |-> int_vector == (int_transaction_server ? 16'h204e : 16'h200e);
	endproperty
	a_ext7: assert property (p_ext7) else $error("source 7 vector wrong");
	property p_fast;
		ce & (|fast_output_unit_evt) |=> pend_reg[3];
	endproperty
	a_fast: assert property (p_fast) else $error("fast output event lost");
	property p_pinsel;
		ce & ctrl_reg[0] & pin_rise[1] |=> pend_reg[7];
	endproperty
	a_pinsel: assert property (p_pinsel) else $error("port-0 pin not selected");
	property p_cap;
		ce & cap_edge |=> capture_reg == $past(timer2_count) && pend_reg[11];
	endproperty
	a_cap: assert property (p_cap) else $error("capture not latched");
	property p_clr;
		ack_fire & ~int_src[4] & ~set_vec[int_src[3:0]] & ~$past(load)
			|=> !pend_reg[$past(int_src[3:0])];
	endproperty
	a_clr: assert property (p_clr) else $error("pending bit not cleared on take");
	c_trap: cover property (load & unimpl_reg);
	c_pts: cover property (load & pts_win);
	c_ack: cover property (ack_fire & int_src == 5'h06);
endmodule

// ==== dv/intp_cpu_model.sv ====
// cpu sequencer model: takes each vector offer and queues what it took
// assumes the offer holds until acknowledged; lat sets how long the cpu dawdles
`timescale 1ns/100ps
module intp_cpu_model (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// bench control
	input wire logic [3:0] lat,
	// vector handshake
	input wire logic int_req,
	input wire logic [15:0] int_vector,
	input wire logic [4:0] int_src,
	input wire logic int_transaction_server,
	output logic int_ack
);
	////////////////////////////////////////////////////////////////////////////////
	// taken offers as {server, source, vector}; a queue so no take is lost while
	// the bench is busy on the register bus
	logic [21:0] q[$];
	logic [3:0] wait_reg;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			int_ack <= 1'b0;
			wait_reg <= 4'h0;
		end else begin
			if (int_req && int_ack) begin
				q.push_back({int_transaction_server, int_src, int_vector});
			end
			// one-cycle ack, never two in a row, so each offer is taken once
			int_ack <= int_req && !int_ack && (wait_reg >= lat);
			wait_reg <= (int_req && !int_ack) ? wait_reg + 4'h1 : 4'h0;
		end
	end
endmodule

// ==== dv/interrupt_prioritizer_vectors_tb.sv ====
// self-checking bench for the interrupt prioritizer and vector unit
// assumes intp_core and the cpu model; registers over axi4-lite
`timescale 1ns/100ps
module interrupt_prioritizer_vectors_tb;
	logic clk = 1'b0, rstn = 1'b0, ce = 1'b1;
	logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	logic [31:0] s_wdata = 32'h0;
	logic [3:0] s_wstrb = 4'hf, lat = 4'h0;
	logic [15:0] periph_evt = 16'h0, timer2_count = 16'h0;
	logic [5:0] fo = 6'h0, pin = 6'h0;
	logic rx = 1'b0, tx = 1'b0, ui = 1'b0, sw = 1'b0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, int_req, int_ack, int_ts;
	logic [1:0] s_bresp, s_rresp;
	logic [31:0] s_rdata;
	logic [15:0] int_vector;
	logic [4:0] int_src;
	int err_count = 0, cmp_count = 0;

	intp_core u_dut (.clk(clk), .rstn(rstn), .ce(ce), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.periph_evt(periph_evt), .fast_output_unit_evt(fo), .receive_done_flag(rx),
		.transmit_done_flag(tx), .unimpl_opcode_trap(ui), .software_trap(sw),
		.timer2_count(timer2_count), .port2_bit2_pin(pin[0]), .port0_bit7_pin(pin[1]),
		.fast_input_unit_pin0(pin[2]), .timer2_capture_input(pin[3]),
		.external_interrupt1_pin(pin[4]), .nmi_pin(pin[5]), .int_req(int_req),
		.int_vector(int_vector), .int_src(int_src), .int_transaction_server(int_ts),
		.int_ack(int_ack));
	intp_cpu_model u_cpu (.clk(clk), .rstn(rstn), .lat(lat), .int_req(int_req),
		.int_vector(int_vector), .int_src(int_src), .int_transaction_server(int_ts),
		.int_ack(int_ack));

	initial begin
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// vector worked out from the vector table, server table from 2040h
	function automatic logic [15:0] vec(input logic [4:0] s, input logic p);
		if (s == 5'h10) return 16'h2012;
		if (s == 5'h11) return 16'h2010;
		return (p ? 16'h2040 : (s < 5'h08) ? 16'h2000 : 16'h2020) + {10'h0, s, 1'b0};
	endfunction

	task automatic tk(input logic [4:0] s, input logic p);
		logic [21:0] e;
		while (u_cpu.q.size() == 0) @(posedge clk);
		e = u_cpu.q.pop_front();
		chk({10'h0, e}, {10'h0, p, s, vec(s, p)});
	endtask

	// nothing further offered: masked or unrouted sources stay quiet
	task automatic none;
		repeat (12) @(posedge clk);
		chk(u_cpu.q.size(), 0);
		chk({31'h0, int_req}, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (s_awvalid && s_awready) begin
				ad = 1'b1;
				s_awvalid <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				wd = 1'b1;
				s_wvalid <= 1'b0;
			end
		end
		while (!s_bvalid) @(posedge clk);
		s_bready <= 1'b0;
		chk({30'h0, s_bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge clk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do @(posedge clk); while (!s_arready);
		s_arvalid <= 1'b0;
		do @(posedge clk); while (!s_rvalid);
		s_rready <= 1'b0;
		chk({s_rdata[31:2], s_rresp}, {exp[31:2], er});
		chk({30'h0, s_rdata[1:0]}, {30'h0, exp[1:0]});
	endtask

	task automatic clr;
		@(posedge clk);
		periph_evt <= 16'h0;
		fo <= 6'h0;
		rx <= 1'b0;
		tx <= 1'b0;
		ui <= 1'b0;
		sw <= 1'b0;
	endtask

	// pins pass a two-flop synchroniser, so they stay high a few cycles
	task automatic rise(input int i);
		@(posedge clk);
		pin[i] <= 1'b1;
		repeat (4) @(posedge clk);
		pin[i] <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rd(intp_pkg::OFS_MASK, 32'h0, intp_pkg::RESP_OKAY);
		rd(intp_pkg::OFS_PTS_SEL, 32'h0, intp_pkg::RESP_OKAY);
		rd(intp_pkg::OFS_CTRL, 32'h0, intp_pkg::RESP_OKAY);
		rd(8'h18, 32'h0, intp_pkg::RESP_SLVERR);
		wr(8'h18, 32'hffff, intp_pkg::RESP_SLVERR);
		wr(intp_pkg::OFS_MASK, 32'ha5a5, intp_pkg::RESP_OKAY);
		rd(intp_pkg::OFS_MASK, 32'ha5a5, intp_pkg::RESP_OKAY);
		wr(intp_pkg::OFS_MASK, 32'h0, intp_pkg::RESP_OKAY);
		@(posedge clk);
		periph_evt <= 16'h0006;
		clr;
		none;
		rd(intp_pkg::OFS_PEND, 32'h0006, intp_pkg::RESP_OKAY);
		// write-one-to-clear drops only the bits written
		wr(intp_pkg::OFS_PEND, 32'h0002, intp_pkg::RESP_OKAY);
		rd(intp_pkg::OFS_PEND, 32'h0004, intp_pkg::RESP_OKAY);
		wr(intp_pkg::OFS_MASK, 32'h0004, intp_pkg::RESP_OKAY);
		tk(5'd2, 1'b0);
		rd(intp_pkg::OFS_PEND, 32'h0, intp_pkg::RESP_OKAY);
		// status keeps the last offer with the request low
		rd(intp_pkg::OFS_STATUS, 32'h2004_0002, intp_pkg::RESP_OKAY);
		$display("registers and pending done");
	endtask

	task automatic t_prio;
		lat <= 4'h6;
		wr(intp_pkg::OFS_PTS_SEL, 32'h0002, intp_pkg::RESP_OKAY);
		wr(intp_pkg::OFS_MASK, 32'hffff, intp_pkg::RESP_OKAY);
		@(posedge clk);
		periph_evt <= 16'hc023;
		clr;
		tk(5'd15, 1'b0);
		tk(5'd1, 1'b1);
		tk(5'd14, 1'b0);
		tk(5'd5, 1'b0);
		tk(5'd0, 1'b0);
		none;
		lat <= 4'h0;
		$display("priority done");
	endtask

	task automatic t_trap;
		wr(intp_pkg::OFS_PTS_SEL, 32'hffff, intp_pkg::RESP_OKAY);
		@(posedge clk);
		periph_evt <= 16'hc000;
		sw <= 1'b1;
		clr;
		tk(5'h11, 1'b0);
		tk(5'd15, 1'b0);
		tk(5'd14, 1'b1);
		@(posedge clk);
		ui <= 1'b1;
		clr;
		tk(5'h10, 1'b0);
		wr(intp_pkg::OFS_PTS_SEL, 32'h0, intp_pkg::RESP_OKAY);
		$display("traps done");
	endtask

	task automatic t_serial;
		wr(intp_pkg::OFS_MASK, 32'h0300, intp_pkg::RESP_OKAY);
		@(posedge clk);
		rx <= 1'b1;
		clr;
		tk(5'd9, 1'b0);
		@(posedge clk);
		tx <= 1'b1;
		clr;
		tk(5'd8, 1'b0);
		wr(intp_pkg::OFS_MASK, 32'h0040, intp_pkg::RESP_OKAY);
		@(posedge clk);
		rx <= 1'b1;
		clr;
		tk(5'd6, 1'b0);
		@(posedge clk);
		tx <= 1'b1;
		clr;
		tk(5'd6, 1'b0);
		none;
		$display("serial done");
	endtask

	task automatic t_ext;
		wr(intp_pkg::OFS_MASK, 32'hffff, intp_pkg::RESP_OKAY);
		wr(intp_pkg::OFS_CTRL, 32'h1, intp_pkg::RESP_OKAY);
		rise(1);
		tk(5'd7, 1'b0);
		wr(intp_pkg::OFS_PTS_SEL, 32'h0080, intp_pkg::RESP_OKAY);
		rise(1);
		tk(5'd7, 1'b1);
		wr(intp_pkg::OFS_PTS_SEL, 32'h0, intp_pkg::RESP_OKAY);
		wr(intp_pkg::OFS_CTRL, 32'h0, intp_pkg::RESP_OKAY);
		rise(1);
		none;
		rise(0);
		tk(5'd7, 1'b0);
		rise(2);
		rise(4);
		rise(5);
		none;
		wr(intp_pkg::OFS_CTRL, 32'he, intp_pkg::RESP_OKAY);
		rise(2);
		tk(5'd4, 1'b0);
		rise(4);
		tk(5'd13, 1'b0);
		rise(5);
		tk(5'd15, 1'b0);
		$display("external pins done");
	endtask

	task automatic t_fast;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			fo <= 6'h01 << i;
			clr;
			tk(5'd3, 1'b0);
		end
		wr(intp_pkg::OFS_PTS_SEL, 32'h0008, intp_pkg::RESP_OKAY);
		@(posedge clk);
		fo <= 6'h3f;
		clr;
		tk(5'd3, 1'b1);
		none;
		timer2_count <= 16'h1234;
		rise(3);
		tk(5'd11, 1'b0);
		timer2_count <= 16'h5a5a;
		rd(intp_pkg::OFS_CAPTURE, 32'h1234, intp_pkg::RESP_OKAY);
		$display("fast output and capture done");
	endtask

	// with the enable low nothing moves, so a pulse in that cycle is not seen
	task automatic t_freeze;
		@(posedge clk);
		ce <= 1'b0;
		periph_evt <= 16'h0004;
		clr;
		ce <= 1'b1;
		none;
		rd(intp_pkg::OFS_PEND, 32'h0, intp_pkg::RESP_OKAY);
		$display("clock enable done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_regs;
		t_prio;
		t_trap;
		t_serial;
		t_ext;
		t_fast;
		t_freeze;
		end_sim;
	end

	// the whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_sim;
	end
endmodule
